// >>> rtl/dcp_pkg.sv
// Constants, encodings and types for the calibration pattern read block
package dcp_pkg;

  // Register port map (byte addresses)
  localparam logic [7:0]  REG_CTRL          = 8'h00;
  localparam logic [7:0]  REG_STATUS        = 8'h04;
  localparam logic [7:0]  REG_MODE          = 8'h08;

  // Control register fields
  localparam int          CTRL_COPY_BIT     = 0;
  localparam int          CTRL_CL_LSB       = 4;
  localparam logic        COPY_RESET        = 1'h0;
  localparam logic [3:0]  CL_RESET          = 4'h6;

  // Status register fields
  localparam int          STAT_MPR_BIT      = 0;
  localparam int          STAT_LOC_LSB      = 1;
  localparam int          STAT_ILLEGAL_BIT  = 3;
  localparam int          STAT_BUSY_BIT     = 4;
  localparam int          STAT_OE_BIT       = 5;

  // Mode register mirror fields
  localparam int          MODE_MR3_LSB      = 0;
  localparam int          MODE_MR0_BL_LSB   = 4;

  // Command codes on {ras_n, cas_n, we_n}
  localparam logic [2:0]  CMD_MRS           = 3'h0;
  localparam logic [2:0]  CMD_WRITE         = 3'h4;
  localparam logic [2:0]  CMD_READ          = 3'h5;
  localparam logic [2:0]  CMD_NOP           = 3'h7;

  // Mode register select on the bank pins
  localparam logic [2:0]  MR_SEL_ZERO       = 3'h0;
  localparam logic [2:0]  MR_SEL_THREE      = 3'h3;

  // Mode register zero burst length field
  localparam int          MR0_BL_LSB        = 0;
  localparam logic [1:0]  BL_FIXED8         = 2'h0;
  localparam logic [1:0]  BL_OTF            = 2'h1;
  localparam logic [1:0]  BL_FIXED4         = 2'h2;

  // Mode register three fields
  localparam int          MR3_LOC_LSB       = 0;
  localparam int          MR3_MPR_BIT       = 2;
  localparam logic [1:0]  LOC_CAL           = 2'h0;

  // Address bits used by reads
  localparam int          A_NIBBLE_BIT      = 2;
  localparam int          A_CHOP_BIT        = 12;

  // Pattern contents, beat zero in the least significant bit
  localparam logic [7:0]  PATTERN_CAL       = 8'haa;
  localparam logic [7:0]  PATTERN_RESERVED  = 8'h00;
  localparam logic [3:0]  BEATS_LONG        = 4'h8;
  localparam logic [3:0]  BEATS_CHOP        = 4'h4;
  localparam logic [2:0]  BEAT_UPPER_HALF   = 3'h4;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAIT,
    PH_BURST
  } dcp_phase_t;

endpackage : dcp_pkg

// >>> rtl/dcp_mpr_read.sv
// Calibration pattern read logic of a double data rate memory device
//
// Function
// [RULE_01] Mode register write to register three with enable set enters pattern mode.
// [RULE_02] Controller precharges all banks and waits before enabling pattern mode.
// [RULE_03] In pattern mode every read and read with precharge returns pattern data; the code ignores a read that arrives while a burst is still pending.
// [RULE_04] Location field of mode register three picks the returned pattern.
// [RULE_05] Only reads are allowed until a mode write clears the enable bit.
// [RULE_06] Read with precharge acts as plain read; no precharge in pattern mode.
// [RULE_07] No power-down, self-refresh or other commands while pattern mode is on.
// [RULE_08] Device reset still works in pattern mode and restores reset state.
// [RULE_09] With enable cleared, reads and writes go to the array as normal.
// [RULE_10] Pattern bit on lane bit zero; upper lane bits copy it or drive zero.
// [RULE_11] Controller drives the two lowest column bits zero; bank bits ignored.
// [RULE_12] Long bursts use column bit two zero and return beats zero to seven.
// [RULE_13] Chopped bursts return beats zero-three or four-seven by column bit two.
// [RULE_14] On-the-fly chop bit honoured when enabled; fixed chop also supported.
// [RULE_15] All other address inputs are ignored during pattern reads.
// [RULE_16] Pattern reads use the same read latency as array reads.
// [RULE_17] Controller waits for clock lock before any pattern read.
// [RULE_18] Beat zero is the pattern's least significant bit, beat seven its most.
// [RULE_19] Location zero returns alternating zero, one across all beats.
// [RULE_20] Controller avoids reserved locations one to three; ordering still holds.
// [RULE_21] Controller waits after the last pattern burst before reloading mode.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module dcp_mpr_read #(
  parameter int A_W = 14
) (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [31:0]     reg_rdata,
  input  wire logic            mem_ck,
  input  wire logic            mem_reset_n,
  input  wire logic            mem_cs_n,
  input  wire logic            mem_ras_n,
  input  wire logic            mem_cas_n,
  input  wire logic            mem_we_n,
  input  wire logic [2:0]      mem_ba,
  input  wire logic [A_W-1:0]  mem_a,
  output logic      [7:0]      lower_byte_lanes,
  output logic      [7:0]      upper_byte_lanes,
  output logic                 lanes_oe,
  output logic                 array_rd,
  output logic                 array_wr,
  output logic      [2:0]      array_ba,
  output logic      [A_W-1:0]  array_a,
  input  wire logic [127:0]    array_rd_data
);

  localparam int PIN_W = 8 + A_W;

  typedef struct packed {
    logic                 ck_s1;
    logic                 ck_s2;
    logic                 ck_prev;
    logic [PIN_W-1:0]     pin_s1;
    logic [PIN_W-1:0]     pin_s2;
    logic [1:0]           mr0_bl;
    logic                 mpr_on;
    logic [1:0]           mpr_loc;
    logic                 copy_all;
    logic [3:0]           cl;
    logic                 illegal;
    dcp_pkg::dcp_phase_t  phase;
    logic [3:0]           lat_cnt;
    logic [2:0]           beat;
    logic [3:0]           left;
    logic                 from_mpr;
    logic [1:0]           rd_loc;
    logic [7:0]           dq_lo;
    logic [7:0]           dq_hi;
    logic                 dq_oe;
    logic [31:0]          rdata;
    logic                 arr_rd;
    logic                 arr_wr;
    logic [2:0]           arr_ba;
    logic [A_W-1:0]       arr_a;
  } dcp_state_t;

  dcp_state_t q;
  dcp_state_t next_q;

  // Pattern bit of one beat for a location
  function automatic logic pattern_bit(input logic [1:0] loc,
                                       input logic [2:0] idx);
    logic [7:0] pat;
    pat = (loc == dcp_pkg::LOC_CAL) ? dcp_pkg::PATTERN_CAL
                                    : dcp_pkg::PATTERN_RESERVED;
    return pat[idx];
  endfunction : pattern_bit

  // Spread the pattern bit over one byte lane
  function automatic logic [7:0] lane_fill(input logic b,
                                           input logic copy);
    return copy ? {8{b}} : {7'h00, b};
  endfunction : lane_fill

  logic                  ck_rise;
  logic                  ck_fall;
  logic                  pin_reset_n;
  logic                  pin_cs_n;
  logic [2:0]            pin_cmd;
  logic [2:0]            pin_ba;
  logic [A_W-1:0]        pin_a;
  logic                  chop;
  logic [2:0]            start_beat;
  logic                  is_read;
  logic                  is_mrs;
  logic [6:0]            slice;

  always_comb
  begin
    ck_rise     = q.ck_s2 & ~q.ck_prev;
    ck_fall     = ~q.ck_s2 & q.ck_prev;
    pin_reset_n = q.pin_s2[PIN_W-1];
    pin_cs_n    = q.pin_s2[PIN_W-2];
    pin_cmd     = q.pin_s2[PIN_W-3 -: 3];
    pin_ba      = q.pin_s2[A_W +: 3];
    pin_a       = q.pin_s2[A_W-1:0];
    is_read     = ~pin_cs_n && pin_cmd == dcp_pkg::CMD_READ;
    is_mrs      = ~pin_cs_n && pin_cmd == dcp_pkg::CMD_MRS;
    // Fixed or on-the-fly chop from mode register zero, see [RULE_14]
    case (q.mr0_bl)
      dcp_pkg::BL_FIXED4: chop = 1'b1;
      dcp_pkg::BL_OTF:    chop = ~pin_a[dcp_pkg::A_CHOP_BIT];
      default:            chop = 1'b0;
    endcase
    // Only column bit two steers the start; others ignored, see [RULE_15]
    if (chop && pin_a[dcp_pkg::A_NIBBLE_BIT])
      start_beat = dcp_pkg::BEAT_UPPER_HALF; // see [RULE_13]
    else
      start_beat = 3'h0; // see [RULE_12]
    slice = {q.beat, 4'h0};
  end

  always_comb
  begin
    next_q        = q;
    next_q.ck_s1  = mem_ck;
    next_q.ck_s2  = q.ck_s1;
    next_q.ck_prev = q.ck_s2;
    next_q.pin_s1 = {mem_reset_n, mem_cs_n, mem_ras_n, mem_cas_n,
                     mem_we_n, mem_ba, mem_a};
    next_q.pin_s2 = q.pin_s1;
    next_q.arr_rd = 1'b0;
    next_q.arr_wr = 1'b0;
    next_q.rdata  = 32'h0000_0000;

    // Register port
    if (reg_wr)
    begin
      case (reg_addr)
        dcp_pkg::REG_CTRL:
        begin
          next_q.copy_all = reg_wdata[dcp_pkg::CTRL_COPY_BIT];
          next_q.cl       = reg_wdata[dcp_pkg::CTRL_CL_LSB +: 4];
        end
        dcp_pkg::REG_STATUS:
          if (reg_wdata[dcp_pkg::STAT_ILLEGAL_BIT])
            next_q.illegal = 1'b0;
        default:
          next_q.illegal = q.illegal;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        dcp_pkg::REG_CTRL:
        begin
          next_q.rdata[dcp_pkg::CTRL_COPY_BIT]    = q.copy_all;
          next_q.rdata[dcp_pkg::CTRL_CL_LSB +: 4] = q.cl;
        end
        dcp_pkg::REG_STATUS:
        begin
          next_q.rdata[dcp_pkg::STAT_MPR_BIT]      = q.mpr_on;
          next_q.rdata[dcp_pkg::STAT_LOC_LSB +: 2] = q.mpr_loc;
          next_q.rdata[dcp_pkg::STAT_ILLEGAL_BIT]  = q.illegal;
          next_q.rdata[dcp_pkg::STAT_BUSY_BIT]     =
            q.phase != dcp_pkg::PH_IDLE;
          next_q.rdata[dcp_pkg::STAT_OE_BIT]       = q.dq_oe;
        end
        dcp_pkg::REG_MODE:
        begin
          next_q.rdata[dcp_pkg::MODE_MR3_LSB +: 3] = {q.mpr_on, q.mpr_loc};
          next_q.rdata[dcp_pkg::MODE_MR0_BL_LSB +: 2] = q.mr0_bl;
        end
        default:
          next_q.rdata = 32'h0000_0000;
      endcase
    end

    // Burst engine, beats on both link clock edges
    case (q.phase)
      dcp_pkg::PH_WAIT:
        if (ck_rise)
        begin
          if (q.lat_cnt <= 4'h1)
          begin
            next_q.phase = dcp_pkg::PH_BURST; // see [RULE_16]
            next_q.dq_oe = 1'b1;
            next_q.beat  = q.beat + 3'h1;
            next_q.left  = q.left - 4'h1;
            if (q.from_mpr)
            begin
              next_q.dq_lo = lane_fill(pattern_bit(q.rd_loc, q.beat),
                                       q.copy_all); // see [RULE_10]
              next_q.dq_hi = lane_fill(pattern_bit(q.rd_loc, q.beat),
                                       q.copy_all); // see [RULE_10]
            end
            else
            begin
              next_q.dq_lo = array_rd_data[slice +: 8];
              next_q.dq_hi = array_rd_data[slice + 7'h08 +: 8];
            end
          end
          else
            next_q.lat_cnt = q.lat_cnt - 4'h1;
        end
      dcp_pkg::PH_BURST:
        if (ck_rise || ck_fall)
        begin
          if (q.left == 4'h0)
          begin
            next_q.phase = dcp_pkg::PH_IDLE;
            next_q.dq_oe = 1'b0;
            next_q.dq_lo = 8'h00;
            next_q.dq_hi = 8'h00;
          end
          else
          begin
            next_q.beat = q.beat + 3'h1; // see [RULE_18]
            next_q.left = q.left - 4'h1;
            if (q.from_mpr)
            begin
              // Beat index picks the pattern bit, see [RULE_19]
              next_q.dq_lo = lane_fill(pattern_bit(q.rd_loc, q.beat),
                                       q.copy_all);
              next_q.dq_hi = lane_fill(pattern_bit(q.rd_loc, q.beat),
                                       q.copy_all);
            end
            else
            begin
              next_q.dq_lo = array_rd_data[slice +: 8];
              next_q.dq_hi = array_rd_data[slice + 7'h08 +: 8];
            end
          end
        end
      default:
        next_q.phase = dcp_pkg::PH_IDLE;
    endcase

    // Command decode on link clock rising edge
    if (ck_rise && pin_reset_n)
    begin
      if (is_mrs && pin_ba == dcp_pkg::MR_SEL_THREE)
      begin
        next_q.mpr_on  = pin_a[dcp_pkg::MR3_MPR_BIT]; // see [RULE_01]
        next_q.mpr_loc = pin_a[dcp_pkg::MR3_LOC_LSB +: 2]; // see [RULE_04]
      end
      else if (is_mrs && pin_ba == dcp_pkg::MR_SEL_ZERO && !q.mpr_on)
        next_q.mr0_bl = pin_a[dcp_pkg::MR0_BL_LSB +: 2];
      if (is_read && q.phase == dcp_pkg::PH_IDLE)
      begin
        next_q.phase    = dcp_pkg::PH_WAIT;
        next_q.lat_cnt  = q.cl;
        next_q.beat     = start_beat;
        next_q.left     = chop ? dcp_pkg::BEATS_CHOP : dcp_pkg::BEATS_LONG;
        next_q.from_mpr = q.mpr_on; // see [RULE_03]
        next_q.rd_loc   = q.mpr_loc; // see [RULE_04]
        // Array read only outside pattern mode, no precharge, see [RULE_06]
        next_q.arr_rd   = ~q.mpr_on; // see [RULE_09]
      end
      if (is_read && !q.mpr_on)
      begin
        next_q.arr_a  = pin_a;
        next_q.arr_ba = pin_ba;
      end
      if (!pin_cs_n && pin_cmd == dcp_pkg::CMD_WRITE && !q.mpr_on)
      begin
        next_q.arr_wr = 1'b1; // see [RULE_09]
        next_q.arr_a  = pin_a;
        next_q.arr_ba = pin_ba;
      end
      // Non-read, non-NOP commands in pattern mode, except a register three mode write, are dropped and flagged
      if (q.mpr_on && !pin_cs_n && !is_read && pin_cmd != dcp_pkg::CMD_NOP
          && !(is_mrs && pin_ba == dcp_pkg::MR_SEL_THREE))
        next_q.illegal = 1'b1; // see [RULE_05]
    end

    // Device reset pin honoured in every mode
    if (!pin_reset_n)
    begin
      next_q.mpr_on  = 1'b0; // see [RULE_08]
      next_q.mpr_loc = 2'h0;
      next_q.mr0_bl  = dcp_pkg::BL_FIXED8;
      next_q.phase   = dcp_pkg::PH_IDLE;
      next_q.dq_oe   = 1'b0;
      next_q.dq_lo   = 8'h00;
      next_q.dq_hi   = 8'h00;
      next_q.arr_rd  = 1'b0;
      next_q.arr_wr  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q          <= '0;
      q.pin_s1   <= {PIN_W{1'b1}};
      q.pin_s2   <= {PIN_W{1'b1}};
      q.mr0_bl   <= dcp_pkg::BL_FIXED8;
      q.copy_all <= dcp_pkg::COPY_RESET;
      q.cl       <= dcp_pkg::CL_RESET;
      q.phase    <= dcp_pkg::PH_IDLE;
    end
    else
      q <= next_q;
  end

  assign reg_rdata        = q.rdata;
  assign lower_byte_lanes = q.dq_lo;
  assign upper_byte_lanes = q.dq_hi;
  assign lanes_oe         = q.dq_oe;
  assign array_rd         = q.arr_rd;
  assign array_wr         = q.arr_wr;
  assign array_ba         = q.arr_ba;
  assign array_a          = q.arr_a;

endmodule : dcp_mpr_read

// >>> tb/dcp_mpr_chk.sv
// Assertion checker for the calibration pattern read block
`timescale 1ns/1ps
module dcp_mpr_chk #(
  parameter int A_W = 14
) (
  input wire logic           clk,
  input wire logic           nrst,
  input wire logic           mem_ck,
  input wire logic           mem_reset_n,
  input wire logic           mem_cs_n,
  input wire logic           mem_ras_n,
  input wire logic           mem_cas_n,
  input wire logic           mem_we_n,
  input wire logic [2:0]     mem_ba,
  input wire logic [A_W-1:0] mem_a,
  input wire logic [7:0]     lower_byte_lanes,
  input wire logic [7:0]     upper_byte_lanes,
  input wire logic           lanes_oe,
  input wire logic           array_rd,
  input wire logic           array_wr
);
  logic [2:0] ck_s;
  logic       pm;
  logic [5:0] oe_n;
  wire        mrs3 = !mem_cs_n && mem_ba == dcp_pkg::MR_SEL_THREE
    && {mem_ras_n, mem_cas_n, mem_we_n} == dcp_pkg::CMD_MRS;
  // Track pattern mode and the length of each driven stretch
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ck_s <= 3'h0;
      pm   <= 1'b0;
      oe_n <= 6'h00;
    end
    else
    begin
      ck_s <= {ck_s[1:0], mem_ck};
      if (!mem_reset_n)
        pm <= 1'b0;
      else if (ck_s[2:1] == 2'b01 && mrs3)
        pm <= mem_a[dcp_pkg::MR3_MPR_BIT];
      oe_n <= lanes_oe ? oe_n + 6'h01 : 6'h00;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_burst;
    $rose(lanes_oe);
  endsequence
  a_lanes_quiet: assert property (
    !lanes_oe |-> lower_byte_lanes == 8'h00 && upper_byte_lanes == 8'h00)
    else $error("lanes not zero while idle");
  a_pattern_lanes: assert property (
    pm && lanes_oe |-> upper_byte_lanes == lower_byte_lanes
    && (lower_byte_lanes[7:1] == 7'h00
    || lower_byte_lanes[7:1] == {7{lower_byte_lanes[0]}}))
    else $error("pattern lanes malformed");
  a_no_array_use: assert property (
    pm && $past(pm, 2) |-> !array_rd && !array_wr)
    else $error("array used in pattern mode");
  a_rd_pulse_one: assert property (
    array_rd |=> !array_rd)
    else $error("array read longer than one cycle");
  a_burst_min: assert property (
    s_burst |-> lanes_oe [*8])
    else $error("burst too short");
  a_burst_max: assert property (
    oe_n <= 6'd32)
    else $error("burst longer than eight beats");
  a_reset_quiet: assert property (
    $fell(mem_reset_n) |-> ##[1:6] !lanes_oe)
    else $error("lanes still driven after device reset");
  a_read_latency: assert property (
    array_rd |-> ##[2:200] $rose(lanes_oe))
    else $error("read burst did not start");
endmodule : dcp_mpr_chk

bind dcp_mpr_read dcp_mpr_chk #(.A_W(A_W)) u_chk (
  .clk(clk), .nrst(nrst), .mem_ck(mem_ck), .mem_reset_n(mem_reset_n),
  .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
  .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_a(mem_a),
  .lower_byte_lanes(lower_byte_lanes), .upper_byte_lanes(upper_byte_lanes),
  .lanes_oe(lanes_oe), .array_rd(array_rd), .array_wr(array_wr));

// >>> tb/dcp_ctrl_model.sv
// Memory controller model driving the link clock and command pins
`timescale 1ns/1ps
module dcp_ctrl_model (
  input  wire logic  clk,
  output logic       mem_ck,
  output logic       mem_reset_n,
  output logic       mem_cs_n,
  output logic [2:0] mem_cmd,
  output logic [2:0] mem_ba,
  output logic [13:0] mem_a
);
  initial
  begin
    {mem_ck, mem_reset_n, mem_cs_n, mem_cmd} = 6'h1f;
    {mem_ba, mem_a} = 17'h0_0000;
    #5.3;
    forever #16 mem_ck = ~mem_ck;
  end
  // Banks stay idle and reads follow lock
  // Reserved locations only probed for ordering
  task cmd(input logic [2:0] code, input logic [2:0] ba,
           input logic [13:0] a);
    repeat (2) @(negedge mem_ck);
    @(posedge clk);
    mem_cs_n <= 1'b0;
    mem_cmd  <= code;
    mem_ba   <= ba;
    mem_a    <= code == dcp_pkg::CMD_READ ? a & 14'h3ffc : a;
    @(negedge mem_ck);
    @(posedge clk);
    mem_cs_n <= 1'b1;
    mem_cmd  <= dcp_pkg::CMD_NOP;
    mem_ba   <= ~ba;
    mem_a    <= ~a;
    repeat (8) @(posedge clk);
  endtask : cmd
  // Pulse the device reset pin
  task dev_reset;
    @(posedge clk);
    mem_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    mem_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : dev_reset
endmodule : dcp_ctrl_model

// >>> tb/testbench.sv
// Self-checking bench for the calibration pattern read block
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic mem_ck, mem_reset_n, mem_cs_n, lanes_oe, array_rd, array_wr;
  logic [2:0] mem_cmd, mem_ba, array_ba;
  logic [13:0] mem_a, array_a;
  logic [7:0] lower, upper;
  logic [15:0] beat [0:7];
  logic [2:0] v_ba [0:3] = '{3'h0, 3'h7, 3'h0, 3'h5};
  logic [13:0] v_a [0:3] = '{14'h1000, 14'h17f8, 14'h0000, 14'h0004};
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int n_ard = 0;
  int n_awr = 0;
  int lat, lat_ref, nb;
  always #2 clk = ~clk;
  dcp_mpr_read #(.A_W(14)) uut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_ck(mem_ck), .mem_reset_n(mem_reset_n), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_cmd[2]), .mem_cas_n(mem_cmd[1]), .mem_we_n(mem_cmd[0]),
    .mem_ba(mem_ba), .mem_a(mem_a), .lower_byte_lanes(lower),
    .upper_byte_lanes(upper), .lanes_oe(lanes_oe), .array_rd(array_rd),
    .array_wr(array_wr), .array_ba(array_ba), .array_a(array_a),
    .array_rd_data(128'h7777_6666_5555_4444_3333_2222_1111_0000));
  dcp_ctrl_model u_ctrl (
    .clk(clk), .mem_ck(mem_ck), .mem_reset_n(mem_reset_n),
    .mem_cs_n(mem_cs_n), .mem_cmd(mem_cmd), .mem_ba(mem_ba), .mem_a(mem_a));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : reg_read
  // Issue a read, time the first beat and capture each beat mid-way
  task lread(input logic [2:0] ba, input logic [13:0] a);
    u_ctrl.cmd(dcp_pkg::CMD_READ, ba, a);
    lat = 0;
    nb = 0;
    while (lanes_oe !== 1'b1 && lat < 400)
    begin
      @(posedge clk);
      lat++;
    end
    @(posedge clk);
    while (lanes_oe === 1'b1 && nb < 8)
    begin
      beat[nb] = {upper, lower};
      nb++;
      repeat (4) @(posedge clk);
    end
    repeat (16) @(posedge clk);
  endtask : lread
  function automatic logic [15:0] pat(int k, logic cp, logic on);
    logic b;
    b = on & k[0];
    return cp ? {16{b}} : {7'h00, b, 7'h00, b};
  endfunction : pat
  always @(posedge clk)
  begin
    cyc++;
    n_ard += array_rd;
    n_awr += array_wr;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    reg_read(dcp_pkg::REG_CTRL);
    check(rd, 32'h0000_0060);
    reg_read(8'h0c);
    check(rd, 32'h0000_0000);
    reg_write(dcp_pkg::REG_CTRL, 32'h0000_0020);
    u_ctrl.cmd(dcp_pkg::CMD_MRS, dcp_pkg::MR_SEL_ZERO, 14'h0001);
    lread(3'h2, 14'h1000);
    lat_ref = lat;
    check(array_a, 14'h1000);
    check(array_ba, 3'h2);
    for (int k = 0; k < 8; k++)
      check(beat[k], {4{k[3:0]}});
    u_ctrl.cmd(dcp_pkg::CMD_MRS, dcp_pkg::MR_SEL_THREE, 14'h0004);
    reg_read(dcp_pkg::REG_STATUS);
    check(rd[2:0], 3'h1);
    reg_read(dcp_pkg::REG_MODE);
    check(rd[5:0], 6'h14);
    for (int i = 0; i < 4; i++)
    begin
      reg_write(dcp_pkg::REG_CTRL, 32'h0000_0020 | 32'(i == 1));
      lread(v_ba[i], v_a[i]);
      check(lat, lat_ref);
      check(nb, i < 2 ? 8 : 4);
      for (int k = 0; k < nb; k++)
        check(beat[k], pat(k + (i == 3 ? 4 : 0), i == 1, 1'b1));
    end
    check(n_ard, 1);
    u_ctrl.cmd(dcp_pkg::CMD_MRS, dcp_pkg::MR_SEL_THREE, 14'h0005);
    lread(3'h0, 14'h1000);
    for (int k = 0; k < 8; k++)
      check(beat[k], pat(k, 1'b1, 1'b0));
    u_ctrl.cmd(dcp_pkg::CMD_WRITE, 3'h0, 14'h0000);
    reg_read(dcp_pkg::REG_STATUS);
    check(rd[3], 1'b1);
    reg_write(dcp_pkg::REG_STATUS, 32'h0000_0008);
    reg_read(dcp_pkg::REG_STATUS);
    check({rd[3], n_awr[0]}, 2'b00);
    u_ctrl.dev_reset();
    reg_read(dcp_pkg::REG_MODE);
    check(rd[5:0], 6'h00);
    u_ctrl.cmd(dcp_pkg::CMD_MRS, dcp_pkg::MR_SEL_THREE, 14'h0004);
    u_ctrl.cmd(dcp_pkg::CMD_MRS, dcp_pkg::MR_SEL_THREE, 14'h0003);
    reg_read(dcp_pkg::REG_STATUS);
    check(rd[0], 1'b0);
    lread(3'h1, 14'h0000);
    check(nb, 8);
    for (int k = 0; k < 8; k++)
      check(beat[k], {4{k[3:0]}});
    u_ctrl.cmd(dcp_pkg::CMD_WRITE, 3'h2, 14'h0040);
    check({n_ard[1:0], n_awr[1:0], array_a}, {4'h9, 14'h0040});
    end_of_test();
  end
endmodule : testbench
